// [rtl/uhcef_pkg.sv]
// constants, types and register map of the host channel event flag block
package uhcef_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] UHCEF_ADDR_CHA_EVENTS = 8'hE6;
    localparam logic [7:0] UHCEF_ADDR_CHB_EVENTS = 8'hE7;
    localparam logic [7:0] UHCEF_EVENTS_RESET    = 8'h00;
    localparam logic [7:0] UHCEF_READ_UNMAPPED   = 8'h00;

    // ==========================================================
    // event register field positions
    localparam int UHCEF_BIT_REQUEST_DONE = 7;
    localparam int UHCEF_BIT_GOOD_COUNT   = 6;
    localparam int UHCEF_BIT_TXN_FAULT    = 5;
    localparam int UHCEF_BIT_OUTCOME_CHG  = 4;
    localparam int UHCEF_BIT_MSS_DONE     = 1;
    localparam int UHCEF_BIT_MSS_ABORT    = 0;

    // ==========================================================
    // sizes and counts
    localparam int              UHCEF_NUM_CH       = 2;
    localparam int              UHCEF_EVENT_W      = 8;
    localparam int              UHCEF_LEN_W        = 11;
    localparam int              UHCEF_TOTAL_W      = 16;
    localparam int              UHCEF_ACK_CNT_W    = 4;
    localparam logic [1:0]      UHCEF_RETRY_STREAK = 2'h3;
    localparam logic [1:0]      UHCEF_STREAK_ZERO  = 2'h0;
    localparam logic [UHCEF_ACK_CNT_W-1:0] UHCEF_ACK_ZERO = 4'h0;
    localparam logic [UHCEF_ACK_CNT_W-1:0] UHCEF_ACK_ONE  = 4'h1;

    // ==========================================================
    // outcome codes; 101..111 are reserved and never produced
    typedef enum logic [2:0] {
        UHCEF_OC_NO_ERROR  = 3'h0,
        UHCEF_OC_STALL     = 3'h1,
        UHCEF_OC_OVERRUN   = 3'h2,
        UHCEF_OC_UNDERRUN  = 3'h3,
        UHCEF_OC_RETRY_ERR = 3'h4
    } uhcef_code_e;

    // ==========================================================
    // end-of-transaction report from the transaction engine
    typedef struct packed {
        logic                     done;
        logic                     is_in;
        logic                     timeout;
        logic                     crc_err;
        logic                     stuff_err;
        logic                     pid_err;
        logic                     toggle_err;
        logic                     stall;
        logic [UHCEF_LEN_W-1:0]   rx_bytes;
        logic [UHCEF_LEN_W-1:0]   packet_size_limit;
        logic [UHCEF_TOTAL_W-1:0] request_bytes_left;
    } uhcef_txn_s;

    // bulk-only sequencer events, channel A only
    typedef struct packed {
        logic status_ok;
        logic xfer_abort;
        logic deact_end;
        logic deact_in_csw;
        logic csw_err;
    } uhcef_bo_s;

endpackage

// [rtl/uhcef_classify.sv]
// outcome classifier for one finished transaction
`timescale 1ns/1ps
module uhcef_classify
    import uhcef_pkg::*;
(
    // transaction report
    input  uhcef_txn_s  txn,
    // classification
    output uhcef_code_e code,
    output logic        fault
);

    logic tog_mismatch;
    logic too_big;
    logic overrun;
    logic underrun;

    // toggle errors on oversize packets count as overrun, not mismatch
    assign tog_mismatch = txn.toggle_err && (txn.rx_bytes <= txn.packet_size_limit);
    assign too_big      = txn.rx_bytes > txn.packet_size_limit;
    assign overrun      = txn.is_in && (too_big
                          || ({5'h00, txn.rx_bytes} > txn.request_bytes_left));
    assign underrun     = txn.is_in && (txn.rx_bytes < txn.packet_size_limit)
                          && ({5'h00, txn.rx_bytes} < txn.request_bytes_left);

    // crc and stuff errors take precedence over size conditions
    assign fault = txn.timeout || txn.crc_err || txn.stuff_err || txn.pid_err
                   || tog_mismatch;

    always_comb begin
        if (fault) begin
            code = UHCEF_OC_RETRY_ERR;
        end else if (txn.stall) begin
            code = UHCEF_OC_STALL;
        end else if (overrun) begin
            code = UHCEF_OC_OVERRUN;
        end else if (underrun) begin
            code = UHCEF_OC_UNDERRUN;
        end else begin
            code = UHCEF_OC_NO_ERROR;
        end
    end

endmodule

// [rtl/uhcef_flagbank.sv]
// bank of sticky event flags, cleared by writing one
`timescale 1ns/1ps
module uhcef_flagbank
    import uhcef_pkg::*;
(
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    // events and clears
    input  wire logic [UHCEF_EVENT_W-1:0] set,
    input  wire logic [UHCEF_EVENT_W-1:0] clr,
    // flags
    output logic      [UHCEF_EVENT_W-1:0] flags_reg
);

    logic [UHCEF_EVENT_W-1:0] flags_next;

    // a set in the clearing cycle wins so the event is not lost
    assign flags_next = (flags_reg & ~clr) | set;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flags_reg <= UHCEF_EVENTS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

endmodule

// [rtl/uhcef_top.sv]
// host channel A/B event flag registers with outcome classification
//
// Chosen here: strobed register access.
`timescale 1ns/1ps

// Contract
// - set fault flag on any transaction error: timeout, crc, stuff, pid, toggle
// - set outcome-change flag on stall, overrun, underrun or three retries in a row
// - clearing run bit sets outcome-change flag; code keeps last transaction result
// - outcome code 000 none, 001 stall, 010 overrun, 011 underrun, 100 retry
// - overrun when packet exceeds size limit or bytes exceed request total
// - crc or stuff error together with overrun or underrun counts as retry
// - toggle mismatch on packet within size limit is mismatch, not overrun
// - underrun on short packet that leaves the request total unfilled
// - retry errors: timeouts, data crc or stuff, pid check, bad pid, toggle
// - channel A sequence-done flag when status transport ends without error
// - on deactivation, done flag when it ends in a clean CSW transport
// - channel A sequence-abort flag when any bulk-only transfer ends abnormally
// - on deactivation, abort flag if outside CSW transport or CSW error
// - channel B event register at E7h, bits 7..4 flags, reset 00h
// - writing 1 clears that flag; bits written 0 are unchanged
// - request-done flag when an IRP-unit transfer finishes without error
// - good-count flag when good transactions reach the programmed count
// - channel A event register at E6h, bits 1..0 bulk-only flags
module uhcef_top
    import uhcef_pkg::*;
(
    // clock and reset
    input  wire logic                                          core_clk,
    input  wire logic                                          resetn,
    // register port
    input  wire logic [7:0]                                    reg_addr,
    input  wire logic [7:0]                                    reg_wdata,
    input  wire logic                                          reg_wr,
    input  wire logic                                          reg_rd,
    output logic      [7:0]                                    reg_rdata,
    // transaction engine, index 0 is channel A, 1 is channel B
    input  uhcef_txn_s [UHCEF_NUM_CH-1:0]                      txn,
    input  wire logic  [UHCEF_NUM_CH-1:0]                      request_done,
    input  wire logic  [UHCEF_NUM_CH-1:0]                      channel_run,
    input  wire logic  [UHCEF_NUM_CH-1:0][UHCEF_ACK_CNT_W-1:0] good_count_target,
    // bulk-only sequencer of channel A
    input  uhcef_bo_s                                          bo_event,
    // per-channel status
    output uhcef_code_e [UHCEF_NUM_CH-1:0]                     outcome_code,
    output logic        [UHCEF_NUM_CH-1:0][UHCEF_EVENT_W-1:0]  event_flags
);

    // ==========================================================
    // register port decode
    logic [UHCEF_NUM_CH-1:0] sel;
    logic [7:0]              rdata_next;

    assign sel[0] = reg_addr == UHCEF_ADDR_CHA_EVENTS;
    assign sel[1] = reg_addr == UHCEF_ADDR_CHB_EVENTS;

    always_comb begin
        rdata_next = UHCEF_READ_UNMAPPED;
        if (sel[0]) begin
            rdata_next = event_flags[0];
        end else if (sel[1]) begin
            rdata_next = event_flags[1];
        end
    end

    // read data stand only in the cycle after the read strobe
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= UHCEF_READ_UNMAPPED;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= UHCEF_READ_UNMAPPED;
        end
    end

    // ==========================================================
    // bulk-only sequence events, channel A only
    logic mss_done_set;
    logic mss_abort_set;

    assign mss_done_set  = bo_event.status_ok
                           || (bo_event.deact_end && bo_event.deact_in_csw
                               && !bo_event.csw_err);
    assign mss_abort_set = bo_event.xfer_abort
                           || (bo_event.deact_end && (!bo_event.deact_in_csw
                               || bo_event.csw_err));

    // ==========================================================
    // per-channel event logic
    genvar ch;
    generate
        for (ch = 0; ch < UHCEF_NUM_CH; ch = ch + 1) begin : g_ch
            uhcef_code_e                txn_code;
            logic                       txn_fault;
            logic                       run_prev_reg;
            logic                       run_fall;
            logic [1:0]                 streak_reg;
            logic [1:0]                 streak_next;
            logic [UHCEF_ACK_CNT_W-1:0] good_reg;
            logic [UHCEF_ACK_CNT_W-1:0] good_next;
            logic                       good_hit;
            logic                       three_retries;
            logic                       code_change;
            logic [UHCEF_EVENT_W-1:0]   set;
            logic [UHCEF_EVENT_W-1:0]   clr;

            uhcef_classify u_classify (
                .txn   (txn[ch]),
                .code  (txn_code),
                .fault (txn_fault)
            );

            // code keeps the last transaction result, also after run stops
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    outcome_code[ch] <= UHCEF_OC_NO_ERROR;
                end else if (txn[ch].done) begin
                    outcome_code[ch] <= txn_code;
                end
            end

            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    run_prev_reg <= 1'b0;
                end else begin
                    run_prev_reg <= channel_run[ch];
                end
            end

            assign run_fall = run_prev_reg && !channel_run[ch];

            // consecutive retry errors; any other outcome breaks the streak
            always_comb begin
                streak_next   = streak_reg;
                three_retries = 1'b0;
                if (txn[ch].done) begin
                    if (txn_code == UHCEF_OC_RETRY_ERR) begin
                        if (streak_reg == UHCEF_RETRY_STREAK - 2'h1) begin
                            three_retries = 1'b1;
                            streak_next   = UHCEF_STREAK_ZERO;
                        end else begin
                            streak_next = streak_reg + 2'h1;
                        end
                    end else begin
                        streak_next = UHCEF_STREAK_ZERO;
                    end
                end else if (run_fall) begin
                    streak_next = UHCEF_STREAK_ZERO;
                end
            end

            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    streak_reg <= UHCEF_STREAK_ZERO;
                end else begin
                    streak_reg <= streak_next;
                end
            end

            // good transaction counter; a zero target never fires
            always_comb begin
                good_next = good_reg;
                good_hit  = 1'b0;
                if (run_fall) begin
                    good_next = UHCEF_ACK_ZERO;
                end else if (txn[ch].done && txn_code == UHCEF_OC_NO_ERROR) begin
                    if (good_count_target[ch] != UHCEF_ACK_ZERO
                        && good_reg + UHCEF_ACK_ONE == good_count_target[ch]) begin
                        good_hit  = 1'b1;
                        good_next = UHCEF_ACK_ZERO;
                    end else begin
                        good_next = good_reg + UHCEF_ACK_ONE;
                    end
                end
            end

            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    good_reg <= UHCEF_ACK_ZERO;
                end else begin
                    good_reg <= good_next;
                end
            end

            assign code_change = txn[ch].done && (txn_code == UHCEF_OC_STALL
                                 || txn_code == UHCEF_OC_OVERRUN
                                 || txn_code == UHCEF_OC_UNDERRUN);

            always_comb begin
                set = UHCEF_EVENTS_RESET;
                set[UHCEF_BIT_REQUEST_DONE] = request_done[ch];
                set[UHCEF_BIT_GOOD_COUNT]   = good_hit;
                set[UHCEF_BIT_TXN_FAULT]    = txn[ch].done && txn_fault;
                set[UHCEF_BIT_OUTCOME_CHG]  = code_change || three_retries
                                              || run_fall;
                if (ch == 0) begin
                    set[UHCEF_BIT_MSS_DONE]  = mss_done_set;
                    set[UHCEF_BIT_MSS_ABORT] = mss_abort_set;
                end
            end

            // only bits written with one are cleared
            assign clr = (reg_wr && sel[ch]) ? reg_wdata : UHCEF_EVENTS_RESET;

            uhcef_flagbank u_flags (
                .core_clk  (core_clk),
                .resetn    (resetn),
                .set       (set),
                .clr       (clr),
                .flags_reg (event_flags[ch])
            );
        end
    endgenerate

endmodule

// [bench/uhcef_ep_model.sv]
// behavioural endpoint: answers each request with one transaction report
`timescale 1ns/1ps
module uhcef_ep_model
    import uhcef_pkg::*;
(
    // clock
    input  wire logic       core_clk,
    // request: answer kind
    input  wire logic       go,
    input  wire logic [2:0] kind,
    // report as the engine hands it on
    output uhcef_txn_s      rpt
);
    // ==========
    // kinds: 0 clean, 1 stall, 2 oversize, 3 short, 4 past total, 5 silent, 6 crc oversize, 7 toggle
    function automatic uhcef_txn_s answer(input logic [2:0] k);
        uhcef_txn_s t;
        t = '0;
        t.done = 1'b1;
        t.is_in = 1'b1;
        t.packet_size_limit = 11'h040;
        t.request_bytes_left = 16'h0064;
        t.rx_bytes = 11'h040;
        case (k)
            3'h1: t.stall = 1'b1;
            3'h2: t.rx_bytes = 11'h041;
            3'h3: t.rx_bytes = 11'h00A;
            3'h4: t.request_bytes_left = 16'h003F;
            3'h5: t.timeout = 1'b1;
            3'h6: begin
                t.crc_err = 1'b1;
                t.rx_bytes = 11'h041;
            end
            3'h7: t.toggle_err = 1'b1;
            default: ;
        endcase
        return t;
    endfunction
    // fields flip between reports so a stale value never looks valid
    function automatic uhcef_txn_s stale(input uhcef_txn_s t);
        uhcef_txn_s s;
        s = ~t;
        s.done = 1'b0;
        return s;
    endfunction
    always @(posedge core_clk) begin
        if (go) begin
            rpt <= answer(kind);
        end else begin
            rpt <= stale(rpt);
        end
    end
endmodule

// [bench/uhcef_top_checker.sv]
// port assertions of the host channel event flag block
`timescale 1ns/1ps
module uhcef_top_checker
    import uhcef_pkg::*;
(
    // clock and reset
    input wire logic                                    core_clk,
    input wire logic                                    resetn,
    // register port
    input wire logic [7:0]                              reg_addr,
    input wire logic [7:0]                              reg_wdata,
    input wire logic                                    reg_wr,
    input wire logic                                    reg_rd,
    input wire logic [7:0]                              reg_rdata,
    // events
    input uhcef_txn_s [UHCEF_NUM_CH-1:0]                txn,
    input wire logic [UHCEF_NUM_CH-1:0]                 request_done,
    input wire logic [UHCEF_NUM_CH-1:0]                 channel_run,
    input wire logic [UHCEF_NUM_CH-1:0][UHCEF_ACK_CNT_W-1:0] good_count_target,
    input uhcef_bo_s                                    bo_event,
    // status
    input uhcef_code_e [UHCEF_NUM_CH-1:0]               outcome_code,
    input wire logic [UHCEF_NUM_CH-1:0][UHCEF_EVENT_W-1:0] event_flags
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire logic b_err = txn[1].timeout | txn[1].crc_err | txn[1].stuff_err | txn[1].pid_err | txn[1].toggle_err;
    wire logic a_clr5 = reg_wr && reg_addr == UHCEF_ADDR_CHA_EVENTS && reg_wdata[5];
    // ==========
    // assertions
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    rd_map_a: assert property (reg_rd && reg_addr == UHCEF_ADDR_CHB_EVENTS
        |=> reg_rdata == $past(event_flags[1]))
        else $error("channel B read wrong");
    resv_zero_a: assert property (event_flags[0][3:2] == 2'h0 && event_flags[1][3:0] == 4'h0)
        else $error("reserved bit set");
    stall_code_a: assert property (txn[1].done && txn[1].stall && !b_err
        |=> outcome_code[1] == UHCEF_OC_STALL && event_flags[1][4])
        else $error("stall not reported");
    fault_set_a: assert property (txn[0].done && txn[0].timeout
        |=> outcome_code[0] == UHCEF_OC_RETRY_ERR && event_flags[0][5])
        else $error("timeout not reported");
    run_fall_a: assert property ($fell(channel_run[1]) |-> ##[1:2] event_flags[1][4])
        else $error("run stop not flagged");
    clr_bit_a: assert property (reg_wr && reg_addr == UHCEF_ADDR_CHB_EVENTS && reg_wdata[7]
        && !request_done[1] |=> !event_flags[1][7])
        else $error("write one did not clear");
    flag_hold_a: assert property (event_flags[0][5] && !a_clr5 |=> event_flags[0][5])
        else $error("flag dropped");
    set_wins_a: assert property (request_done[1] |=> event_flags[1][7])
        else $error("request done lost");
    seq_done_a: assert property (bo_event.status_ok |=> event_flags[0][1])
        else $error("sequence done lost");
    seq_stop_a: assert property (bo_event.deact_end && !bo_event.deact_in_csw |=> event_flags[0][0])
        else $error("sequence abort lost");
    cover property (reg_rd ##1 reg_rdata != 8'h00);
    cover property ($fell(channel_run[1]));
    cover property (request_done[1] && reg_wr);
endmodule
bind uhcef_top uhcef_top_checker u_chk (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .txn, .request_done, .channel_run, .good_count_target, .bo_event, .outcome_code, .event_flags);

// [bench/usb_host_channel_event_flags_tb.sv]
// register-level bench of the host channel event flag block
`timescale 1ns/1ps
module usb_host_channel_event_flags_tb
    import uhcef_pkg::*;
;
    logic              core_clk, resetn, reg_wr, reg_rd;
    logic [7:0]        reg_addr, reg_wdata, reg_rdata;
    logic [1:0]        request_done, channel_run, go;
    logic [1:0][2:0]   kind;
    logic [1:0][3:0]   good_count_target;
    uhcef_bo_s         bo_event;
    uhcef_txn_s [1:0]  txn;
    uhcef_code_e [1:0] outcome_code;
    logic [1:0][7:0]   event_flags;
    int                err_total, check_count;
    localparam logic [2:0] EXP_CODE [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h2, 3'h4, 3'h4, 3'h4};
    localparam logic [7:0] EXP_FLAG [8] = '{8'h00, 8'h10, 8'h10, 8'h10, 8'h10, 8'h20, 8'h20, 8'h30};
    uhcef_top DUT (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .txn, .request_done,
        .channel_run, .good_count_target, .bo_event, .outcome_code, .event_flags);
    uhcef_ep_model u_ep_a (.core_clk, .go(go[0]), .kind(kind[0]), .rpt(txn[0]));
    uhcef_ep_model u_ep_b (.core_clk, .go(go[1]), .kind(kind[1]), .rpt(txn[1]));
    // ==========
    // tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    // one edge; every strobe and pulse is dropped after it
    task automatic cyc();
        @(posedge core_clk);
        request_done <= 2'h0;
        bo_event <= '0;
        go <= 2'h0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cyc();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string m);
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc();
        chk(reg_rdata, exp, m);
    endtask
    task automatic send(input int ch, input logic [2:0] k);
        go[ch] <= 1'b1;
        kind[ch] <= k;
        cyc();
        cyc();
    endtask
    task automatic deact(input logic in_csw, input logic err, input logic [7:0] exp);
        bo_event.deact_end <= 1'b1;
        bo_event.deact_in_csw <= in_csw;
        bo_event.csw_err <= err;
        cyc();
        rd(UHCEF_ADDR_CHA_EVENTS, exp, "deactivation");
        wr(UHCEF_ADDR_CHA_EVENTS, 8'hFF);
    endtask
    // ==========
    // clock, watchdog, sequence
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        $display("mismatch at %0t: run timed out", $time);
        give_verdict();
    end
    initial begin
        err_total = 0;
        check_count = 0;
        resetn = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, request_done, go, kind} = '0;
        bo_event = '0;
        channel_run = 2'h3;
        good_count_target = {4'h0, 4'h2};
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        cyc();
        rd(UHCEF_ADDR_CHA_EVENTS, UHCEF_EVENTS_RESET, "A reset");
        rd(UHCEF_ADDR_CHB_EVENTS, UHCEF_EVENTS_RESET, "B reset");
        rd(8'hE8, UHCEF_READ_UNMAPPED, "unmapped");
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            send(1, k[2:0]);
            chk(8'(outcome_code[1]), 8'(EXP_CODE[k]), "code");
            rd(UHCEF_ADDR_CHB_EVENTS, EXP_FLAG[k], "B flags");
            wr(UHCEF_ADDR_CHB_EVENTS, 8'hFF);
        end
        rd(UHCEF_ADDR_CHB_EVENTS, 8'h00, "B cleared");
        channel_run[1] <= 1'b0;
        cyc();
        cyc();
        rd(UHCEF_ADDR_CHB_EVENTS, 8'h10, "run stop");
        chk(8'(outcome_code[1]), 8'(UHCEF_OC_RETRY_ERR), "kept code");
        wr(UHCEF_ADDR_CHB_EVENTS, 8'hFF);
        channel_run[1] <= 1'b1;
        $display("test outcome done");
        send(0, 3'h0);
        chk(event_flags[0], 8'h00, "count one");
        send(0, 3'h0);
        chk(event_flags[0], 8'h40, "count two");
        request_done[0] <= 1'b1;
        bo_event.status_ok <= 1'b1;
        bo_event.xfer_abort <= 1'b1;
        cyc();
        rd(UHCEF_ADDR_CHA_EVENTS, 8'hC3, "A all");
        wr(UHCEF_ADDR_CHA_EVENTS, 8'h03);
        rd(UHCEF_ADDR_CHA_EVENTS, 8'hC0, "A partial");
        wr(UHCEF_ADDR_CHA_EVENTS, 8'hC0);
        deact(1'b1, 1'b0, 8'h02);
        deact(1'b1, 1'b1, 8'h01);
        deact(1'b0, 1'b0, 8'h01);
        $display("test channel A done");
        request_done[1] <= 1'b1;
        wr(UHCEF_ADDR_CHB_EVENTS, 8'h80);
        cyc();
        rd(UHCEF_ADDR_CHB_EVENTS, 8'h80, "set wins");
        send(0, 3'h5);
        cyc();
        rd(UHCEF_ADDR_CHA_EVENTS, 8'h20, "A fault held");
        $display("test priority done");
        give_verdict();
    end
endmodule
